// >>> cfgr_pkg.sv
`default_nettype none
package cfgr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices as loaded into the configuration index register
    localparam logic [7:0] IDX_DRIVE_TYPE   = 8'h06;
    localparam logic [7:0] IDX_AUTOPOWER    = 8'h07;
    localparam logic [7:0] IDX_DEC_LOW      = 8'h08;
    localparam logic [7:0] IDX_DEC_HIGH     = 8'h09;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_INDEX        = 8'h00;
    localparam logic [7:0] RST_DRIVE_TYPE   = 8'hFF;
    localparam logic [7:0] RST_AUTOPOWER    = 8'h00;
    localparam logic [7:0] RST_DEC_LOW      = 8'h00;
    localparam logic [7:0] RST_DEC_HIGH     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and writable-bit masks
    localparam int         DRIVE_ID_W       = 2;
    localparam int         BOOT_LSB         = 0;
    localparam int         BOOT_W           = 2;
    localparam int         APD_LPT_BIT      = 4;
    localparam int         APD_UART2_BIT    = 5;
    localparam int         APD_UART1_BIT    = 6;
    localparam int         APD_FDC_BIT      = 7;
    localparam logic [7:0] APD_BITS_MASK    = 8'hF0;
    localparam logic [7:0] AUTOPOWER_WMASK  = 8'hF3;
    localparam logic [7:0] DEC_LOW_WMASK    = 8'hF0;
    localparam logic [7:0] DEC_HIGH_WMASK   = 8'hCF;
    localparam int         DEC_LOW_LSB      = 4;
    localparam int         DEC_HIGH_LSB     = 0;
    localparam int         DEC_CFG_LSB      = 6;
    localparam logic [3:0] HOST_TOP_ZERO    = 4'h0;
    localparam logic [3:0] BYTE_OFFSET_ZERO = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // decoder size selection
    typedef enum logic [1:0] {
        DEC_OFF   = 2'h0,
        DEC_BYTE  = 2'h1,
        DEC_BLK8  = 2'h2,
        DEC_BLK16 = 2'h3
    } cfgr_dec_mode_e;

endpackage
`default_nettype wire

// >>> cfgr_index.sv
`timescale 1ns/10ps
`default_nettype none
module cfgr_index (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       cfg_state,
    input  wire logic       cfg_index_wr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] config_index_reg
);

    logic [7:0] index_r;
    logic [7:0] index_nxt;

    // index only moves while configuration state is open
    always_comb begin
        index_nxt = index_r;
        if (cfg_state && cfg_index_wr) begin
            index_nxt = cfg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            index_r <= cfgr_pkg::RST_INDEX;
        end else begin
            index_r <= index_nxt;
        end
    end

    assign config_index_reg = index_r;

endmodule
`default_nettype wire

// >>> cfgr_decode.sv
`timescale 1ns/10ps
`default_nettype none
module cfgr_decode (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire logic [15:0]               io_addr,
    input  wire logic [3:0]                decode_match_low_bits,
    input  wire logic [3:0]                decode_match_high_bits,
    input  wire cfgr_pkg::cfgr_dec_mode_e  dec_mode,
    output logic                           gp_decode_select_n
);

    logic sel_n_r;
    logic sel_n_nxt;
    logic page_hit;

    // upper nibble must be zero and A11:A4 must equal the programmed bits
    assign page_hit = (io_addr[15:12] == cfgr_pkg::HOST_TOP_ZERO) &&
                      (io_addr[11:8] == decode_match_high_bits) &&
                      (io_addr[7:4] == decode_match_low_bits);

    // the select is registered so it never glitches while the address settles
    always_comb begin
        sel_n_nxt = 1'b1;
        case (dec_mode)
            cfgr_pkg::DEC_OFF: begin
                sel_n_nxt = 1'b1;
            end
            cfgr_pkg::DEC_BYTE: begin
                sel_n_nxt = !(page_hit && (io_addr[3:0] == cfgr_pkg::BYTE_OFFSET_ZERO));
            end
            cfgr_pkg::DEC_BLK8: begin
                sel_n_nxt = !(page_hit && !io_addr[3]);
            end
            cfgr_pkg::DEC_BLK16: begin
                sel_n_nxt = !page_hit;
            end
            default: begin
                sel_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sel_n_r <= 1'b1;
        end else begin
            sel_n_r <= sel_n_nxt;
        end
    end

    assign gp_decode_select_n = sel_n_r;

endmodule
`default_nettype wire

// >>> cfgr_bank.sv
// What this block does
// - drive type reg at index 06H, resets FFH
// - two-bit type ID per drive slot
// - power/boot reg at index 07H, resets 00H
// - bits 1:0 select boot drive A or B
// - bit 4 enables parallel port auto power-down
// - bit 5 enables second UART auto power-down
// - bit 6 enables first UART auto power-down
// - bit 7 enables floppy auto power-down
// - power-down enables clear on power-on or hardware reset
// - decoder low reg at index 08H, resets 00H
// - low reg holds A7:A4, low nibble zero
// - decoder high reg at index 09H, resets 00H
// - high reg holds A11:A8 and mode bits
// - select needs A11:A4 match, A15:A12 zero
// - mode picks off, byte, 8 or 16 block
`timescale 1ns/10ps
`default_nettype none
module cfgr_bank (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        hard_reset,
    input  wire logic        cfg_state,
    input  wire logic        cfg_index_wr,
    input  wire logic        cfg_data_wr,
    input  wire logic        cfg_data_rd,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic [15:0] io_addr,
    output logic      [7:0]  cfg_rdata,
    output logic             cfg_rdata_valid,
    output logic             cfg_rdata_hit,
    output logic      [7:0]  drive_type_ids,
    output logic      [1:0]  drive_slot_0,
    output logic      [1:0]  drive_slot_1,
    output logic      [1:0]  drive_slot_2,
    output logic      [1:0]  drive_slot_3,
    output logic      [1:0]  boot_drive_sel,
    output logic             auto_power_a_lpt,
    output logic             auto_power_a_uart2,
    output logic             auto_power_a_uart1,
    output logic             auto_power_a_fdc,
    output logic             gp_decode_select_n
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] config_index_reg;
    logic [7:0] drive_type_r;
    logic [7:0] drive_type_nxt;
    logic [7:0] autopower_r;
    logic [7:0] autopower_nxt;
    logic [7:0] dec_low_r;
    logic [7:0] dec_low_nxt;
    logic [7:0] dec_high_r;
    logic [7:0] dec_high_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;
    logic       rhit_r;
    logic       rhit_nxt;
    logic       wr_ok;
    logic       rd_ok;

    cfgr_pkg::cfgr_dec_mode_e dec_mode;

    // merge a write into a register, keeping bits that do not take writes
    function automatic logic [7:0] masked_write(input logic [7:0] old_val,
                                                input logic [7:0] new_val,
                                                input logic [7:0] wmask);
        masked_write = (old_val & ~wmask) | (new_val & wmask);
    endfunction

    // true when the index selects one of this bank's registers
    function automatic logic index_mapped(input logic [7:0] idx);
        index_mapped = (idx == cfgr_pkg::IDX_DRIVE_TYPE) || (idx == cfgr_pkg::IDX_AUTOPOWER) ||
                       (idx == cfgr_pkg::IDX_DEC_LOW) || (idx == cfgr_pkg::IDX_DEC_HIGH);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // index register

    cfgr_index u_index (
        .core_clk         (core_clk),
        .nrst             (nrst),
        .cfg_state        (cfg_state),
        .cfg_index_wr     (cfg_index_wr),
        .cfg_wdata        (cfg_wdata),
        .config_index_reg (config_index_reg)
    );

    // data port is dead outside configuration state
    assign wr_ok = cfg_state && cfg_data_wr;
    assign rd_ok = cfg_state && cfg_data_rd;

    ////////////////////////////////////////////////////////////////////////////
    // register file next values

    always_comb begin
        drive_type_nxt = drive_type_r;
        autopower_nxt  = autopower_r;
        dec_low_nxt    = dec_low_r;
        dec_high_nxt   = dec_high_r;
        if (wr_ok) begin
            case (config_index_reg)
                cfgr_pkg::IDX_DRIVE_TYPE: begin
                    drive_type_nxt = cfg_wdata;
                end
                cfgr_pkg::IDX_AUTOPOWER: begin
                    autopower_nxt = masked_write(autopower_r, cfg_wdata, cfgr_pkg::AUTOPOWER_WMASK);
                end
                cfgr_pkg::IDX_DEC_LOW: begin
                    dec_low_nxt = masked_write(dec_low_r, cfg_wdata, cfgr_pkg::DEC_LOW_WMASK);
                end
                cfgr_pkg::IDX_DEC_HIGH: begin
                    dec_high_nxt = masked_write(dec_high_r, cfg_wdata, cfgr_pkg::DEC_HIGH_WMASK);
                end
                default: begin
                    drive_type_nxt = drive_type_r;
                end
            endcase
        end
        // hardware reset beats a write in the same cycle for the enables only
        if (hard_reset) begin
            autopower_nxt = autopower_nxt & ~cfgr_pkg::APD_BITS_MASK;
        end
    end

    // power-on reset restores every register; boot select and decoder survive hard_reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            drive_type_r <= cfgr_pkg::RST_DRIVE_TYPE;
            autopower_r  <= cfgr_pkg::RST_AUTOPOWER;
            dec_low_r    <= cfgr_pkg::RST_DEC_LOW;
            dec_high_r   <= cfgr_pkg::RST_DEC_HIGH;
        end else begin
            drive_type_r <= drive_type_nxt;
            autopower_r  <= autopower_nxt;
            dec_low_r    <= dec_low_nxt;
            dec_high_r   <= dec_high_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: data appears the cycle after the read strobe

    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        rhit_nxt   = 1'b0;
        if (rd_ok) begin
            rvalid_nxt = 1'b1;
            rhit_nxt   = index_mapped(config_index_reg);
            // unmapped indices read zero so another bank can drive the bus
            case (config_index_reg)
                cfgr_pkg::IDX_DRIVE_TYPE: begin
                    rdata_nxt = drive_type_r;
                end
                cfgr_pkg::IDX_AUTOPOWER: begin
                    rdata_nxt = autopower_r & cfgr_pkg::AUTOPOWER_WMASK;
                end
                cfgr_pkg::IDX_DEC_LOW: begin
                    rdata_nxt = dec_low_r & cfgr_pkg::DEC_LOW_WMASK;
                end
                cfgr_pkg::IDX_DEC_HIGH: begin
                    rdata_nxt = dec_high_r & cfgr_pkg::DEC_HIGH_WMASK;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            rhit_r   <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            rhit_r   <= rhit_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // general-purpose address decoder

    assign dec_mode = cfgr_pkg::cfgr_dec_mode_e'(dec_high_r[cfgr_pkg::DEC_CFG_LSB +: 2]);

    cfgr_decode u_decode (
        .core_clk               (core_clk),
        .nrst                   (nrst),
        .io_addr                (io_addr),
        .decode_match_low_bits  (dec_low_r[cfgr_pkg::DEC_LOW_LSB +: 4]),
        .decode_match_high_bits (dec_high_r[cfgr_pkg::DEC_HIGH_LSB +: 4]),
        .dec_mode               (dec_mode),
        .gp_decode_select_n     (gp_decode_select_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all taken straight from register bits

    assign cfg_rdata          = rdata_r;
    assign cfg_rdata_valid    = rvalid_r;
    assign cfg_rdata_hit      = rhit_r;
    assign drive_type_ids     = drive_type_r;
    assign drive_slot_0       = drive_type_r[0*cfgr_pkg::DRIVE_ID_W +: cfgr_pkg::DRIVE_ID_W];
    assign drive_slot_1       = drive_type_r[1*cfgr_pkg::DRIVE_ID_W +: cfgr_pkg::DRIVE_ID_W];
    assign drive_slot_2       = drive_type_r[2*cfgr_pkg::DRIVE_ID_W +: cfgr_pkg::DRIVE_ID_W];
    assign drive_slot_3       = drive_type_r[3*cfgr_pkg::DRIVE_ID_W +: cfgr_pkg::DRIVE_ID_W];
    assign boot_drive_sel     = autopower_r[cfgr_pkg::BOOT_LSB +: cfgr_pkg::BOOT_W];
    assign auto_power_a_lpt   = autopower_r[cfgr_pkg::APD_LPT_BIT];
    assign auto_power_a_uart2 = autopower_r[cfgr_pkg::APD_UART2_BIT];
    assign auto_power_a_uart1 = autopower_r[cfgr_pkg::APD_UART1_BIT];
    assign auto_power_a_fdc   = autopower_r[cfgr_pkg::APD_FDC_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // a data write to a given index while configuration state is open
    sequence s_write_to(logic [7:0] idx);
        cfg_state && cfg_data_wr && (config_index_reg == idx) && !hard_reset;
    endsequence

    // a data read while configuration state is open
    sequence s_read_of(logic [7:0] idx);
        cfg_state && cfg_data_rd && (config_index_reg == idx);
    endsequence

    a_drive_reset_val: assert property (@(posedge core_clk)
        !nrst |=> (drive_type_ids == 8'hFF))
        else $error("drive type register not FF after reset");

    a_drive_write_path: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(8'h06) |=> (drive_slot_3 == $past(cfg_wdata[7:6])) && (drive_slot_0 == $past(cfg_wdata[1:0])))
        else $error("drive slot fields do not follow the write");

    a_boot_write_path: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(8'h07) |=> (boot_drive_sel == $past(cfg_wdata[1:0])) &&
            (auto_power_a_uart2 == $past(cfg_wdata[5])))
        else $error("power register fields do not follow the write");

    a_apd_hard_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        hard_reset |=> !auto_power_a_lpt && !auto_power_a_uart1 && !auto_power_a_uart2 && !auto_power_a_fdc)
        else $error("auto power-down enable survived hardware reset");

    a_apd_reset_val: assert property (@(posedge core_clk)
        !nrst |=> (boot_drive_sel == 2'h0) && !auto_power_a_fdc && gp_decode_select_n)
        else $error("power register or select not at default after reset");

    a_low_reads_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        s_read_of(8'h08) |=> cfg_rdata_valid && cfg_rdata_hit && (cfg_rdata[3:0] == 4'h0))
        else $error("low decoder register low nibble not zero on read");

    a_high_read_back: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(8'h09) ##1 s_read_of(8'h09) |=> (cfg_rdata == ($past(cfg_wdata, 2) & 8'hCF)))
        else $error("high decoder register read back wrong");

    a_closed_no_write: assert property (@(posedge core_clk) disable iff (!nrst)
        (!cfg_state && !hard_reset) |=> $stable(drive_type_ids) && $stable(dec_low_r) && $stable(dec_high_r) &&
            $stable(autopower_r))
        else $error("register changed outside configuration state");

    a_select_top_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        !gp_decode_select_n |-> ($past(io_addr[15:12]) == 4'h0) &&
            ($past(io_addr[11:4]) == {$past(dec_high_r[3:0]), $past(dec_low_r[7:4])}))
        else $error("select asserted without an address match");

    a_select_off_mode: assert property (@(posedge core_clk) disable iff (!nrst)
        (dec_high_r[7:6] == 2'h0) |=> gp_decode_select_n)
        else $error("select asserted while decoder disabled");

    a_select_byte_hit: assert property (@(posedge core_clk) disable iff (!nrst)
        ((dec_high_r[7:6] == 2'h1) && (io_addr == {4'h0, dec_high_r[3:0], dec_low_r[7:4], 4'h0}))
            |=> !gp_decode_select_n)
        else $error("single byte decode missed its address");

    a_select_blk8_a3: assert property (@(posedge core_clk) disable iff (!nrst)
        ((dec_high_r[7:6] == 2'h2) && io_addr[3]) |=> gp_decode_select_n)
        else $error("eight byte decode hit with A3 set");

    ////////////////////////////////////////////////////////////////////////////
    // checks on single fields, the index, the read strobe and the sixteen byte decode

    // a read strobe that the bank takes
    sequence s_read_taken;
        cfg_state && cfg_data_rd;
    endsequence

    // a hardware reset with no data write in the same cycle
    sequence s_hard_alone;
        hard_reset && !(cfg_state && cfg_data_wr);
    endsequence

    a_drive_mid_slots: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(cfgr_pkg::IDX_DRIVE_TYPE) |=> (drive_slot_1 == $past(cfg_wdata[3:2])) &&
            (drive_slot_2 == $past(cfg_wdata[5:4])))
        else $error("middle drive slots do not follow the write");

    a_lpt_write_path: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(cfgr_pkg::IDX_AUTOPOWER) |=> (auto_power_a_lpt == $past(cfg_wdata[4])))
        else $error("parallel port enable does not follow the write");

    a_uart1_write_path: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(cfgr_pkg::IDX_AUTOPOWER) |=> (auto_power_a_uart1 == $past(cfg_wdata[6])))
        else $error("first serial enable does not follow the write");

    a_fdc_write_path: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(cfgr_pkg::IDX_AUTOPOWER) |=> (auto_power_a_fdc == $past(cfg_wdata[7])))
        else $error("floppy enable does not follow the write");

    a_hard_keeps_boot: assert property (@(posedge core_clk) disable iff (!nrst)
        s_hard_alone |=> (boot_drive_sel == $past(boot_drive_sel)))
        else $error("boot select changed by hardware reset");

    a_low_write_path: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(cfgr_pkg::IDX_DEC_LOW) |=> (dec_low_r == ($past(cfg_wdata) & cfgr_pkg::DEC_LOW_WMASK)))
        else $error("low decoder register does not follow the write");

    a_high_write_path: assert property (@(posedge core_clk) disable iff (!nrst)
        s_write_to(cfgr_pkg::IDX_DEC_HIGH) |=> (dec_high_r == ($past(cfg_wdata) & cfgr_pkg::DEC_HIGH_WMASK)))
        else $error("high decoder register does not follow the write");

    a_index_closed: assert property (@(posedge core_clk) disable iff (!nrst)
        !cfg_state |=> $stable(config_index_reg))
        else $error("index moved outside configuration state");

    a_read_answer: assert property (@(posedge core_clk) disable iff (!nrst)
        s_read_taken |=> cfg_rdata_valid)
        else $error("read strobe got no answer");

    a_no_read_no_valid: assert property (@(posedge core_clk) disable iff (!nrst)
        !(cfg_state && cfg_data_rd) |=> !cfg_rdata_valid && !cfg_rdata_hit)
        else $error("read answer without a taken read");

    a_rdata_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        !(cfg_state && cfg_data_rd) |=> $stable(cfg_rdata))
        else $error("read data moved without a read");

    a_unmapped_read: assert property (@(posedge core_clk) disable iff (!nrst)
        (cfg_state && cfg_data_rd && !index_mapped(config_index_reg)) |=>
            !cfg_rdata_hit && (cfg_rdata == 8'h00))
        else $error("unmapped index answered");

    a_select_blk16_hit: assert property (@(posedge core_clk) disable iff (!nrst)
        ((dec_high_r[7:6] == 2'h3) && (io_addr[15:4] == {4'h0, dec_high_r[3:0], dec_low_r[7:4]}))
            |=> !gp_decode_select_n)
        else $error("sixteen byte decode missed its block");

endmodule
`default_nettype wire

// >>> cfgr_host.sv
`timescale 1ns/10ps
`default_nettype none
module cfgr_host (
    input  wire logic        core_clk,
    output logic             cfg_state,
    output logic             cfg_index_wr,
    output logic             cfg_data_wr,
    output logic             cfg_data_rd,
    output logic      [7:0]  cfg_wdata,
    output logic      [15:0] io_addr
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero, configuration state open
    initial begin
        cfg_state = 1'b1;
        cfg_index_wr = 1'b0;
        cfg_data_wr = 1'b0;
        cfg_data_rd = 1'b0;
        cfg_wdata = 8'h00;
        io_addr = 16'hFFFF;
    end

    // open or close configuration state between accesses
    task automatic open_cfg(input logic on);
        @(negedge core_clk);
        cfg_state = on;
    endtask

    // index then data; released data shows the inverse so stale data never looks live
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
        @(negedge core_clk);
        cfg_index_wr = 1'b1;
        cfg_wdata = idx;
        @(negedge core_clk);
        cfg_index_wr = 1'b0;
        cfg_data_wr = 1'b1;
        cfg_wdata = val;
        @(negedge core_clk);
        cfg_data_wr = 1'b0;
        cfg_wdata = ~val;
    endtask

    // returns at the falling edge where the read answer stands
    task automatic reg_rd(input logic [7:0] idx);
        @(negedge core_clk);
        cfg_index_wr = 1'b1;
        cfg_wdata = idx;
        @(negedge core_clk);
        cfg_index_wr = 1'b0;
        cfg_data_rd = 1'b1;
        cfg_wdata = ~idx;
        @(negedge core_clk);
        cfg_data_rd = 1'b0;
    endtask

    // index, data write and data read on three edges in a row
    task automatic reg_wr_rd(input logic [7:0] idx, input logic [7:0] val);
        @(negedge core_clk);
        cfg_index_wr = 1'b1;
        cfg_wdata = idx;
        @(negedge core_clk);
        cfg_index_wr = 1'b0;
        cfg_data_wr = 1'b1;
        cfg_wdata = val;
        @(negedge core_clk);
        cfg_data_wr = 1'b0;
        cfg_data_rd = 1'b1;
        cfg_wdata = ~val;
        @(negedge core_clk);
        cfg_data_rd = 1'b0;
    endtask

    // host address presented for one decode sample
    task automatic set_addr(input logic [15:0] a);
        @(negedge core_clk);
        io_addr = a;
    endtask
endmodule
`default_nettype wire

// >>> test_cfgr_bank.sv
`timescale 1ns/10ps
`default_nettype none
module test_cfgr_bank;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic hard_reset = 1'b0;
    logic cfg_state, cfg_index_wr, cfg_data_wr, cfg_data_rd;
    logic [7:0] cfg_wdata, cfg_rdata, drive_type_ids;
    logic [15:0] io_addr;
    logic cfg_rdata_valid, cfg_rdata_hit, gp_decode_select_n;
    logic [1:0] drive_slot_0, drive_slot_1, drive_slot_2, drive_slot_3, boot_drive_sel;
    logic auto_power_a_lpt, auto_power_a_uart2, auto_power_a_uart1, auto_power_a_fdc;
    int fails = 0;
    int comparisons = 0;

    ////////////////////////////////////////////////////////////////////////////
    // clock, host model and device
    always #10 core_clk = ~core_clk;

    cfgr_host host (.core_clk(core_clk), .cfg_state(cfg_state), .cfg_index_wr(cfg_index_wr),
        .cfg_data_wr(cfg_data_wr), .cfg_data_rd(cfg_data_rd), .cfg_wdata(cfg_wdata), .io_addr(io_addr));

    cfgr_bank dut (.core_clk(core_clk), .nrst(nrst), .hard_reset(hard_reset), .cfg_state(cfg_state),
        .cfg_index_wr(cfg_index_wr), .cfg_data_wr(cfg_data_wr), .cfg_data_rd(cfg_data_rd),
        .cfg_wdata(cfg_wdata), .io_addr(io_addr), .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid),
        .cfg_rdata_hit(cfg_rdata_hit), .drive_type_ids(drive_type_ids), .drive_slot_0(drive_slot_0),
        .drive_slot_1(drive_slot_1), .drive_slot_2(drive_slot_2), .drive_slot_3(drive_slot_3),
        .boot_drive_sel(boot_drive_sel), .auto_power_a_lpt(auto_power_a_lpt),
        .auto_power_a_uart2(auto_power_a_uart2), .auto_power_a_uart1(auto_power_a_uart1),
        .auto_power_a_fdc(auto_power_a_fdc), .gp_decode_select_n(gp_decode_select_n));

    ////////////////////////////////////////////////////////////////////////////
    // shared compare and read helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic hit);
        host.reg_rd(idx);
        chk({8'h00, cfg_rdata}, {8'h00, exp});
        chk({15'h0, cfg_rdata_valid}, 16'h1);
        chk({15'h0, cfg_rdata_hit}, {15'h0, hit});
        @(negedge core_clk);
        chk({15'h0, cfg_rdata_valid}, 16'h0);
    endtask

    function automatic logic [3:0] apd();
        return {auto_power_a_fdc, auto_power_a_uart1, auto_power_a_uart2, auto_power_a_lpt};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rd_chk(8'h06, 8'hFF, 1'b1);
        rd_chk(8'h07, 8'h00, 1'b1);
        rd_chk(8'h08, 8'h00, 1'b1);
        rd_chk(8'h09, 8'h00, 1'b1);
        chk({12'h0, apd()}, 16'h0);
        chk({15'h0, gp_decode_select_n}, 16'h1);
    endtask

    task automatic t_fields();
        host.reg_wr(8'h06, 8'hE4);
        chk({drive_slot_3, drive_slot_2, drive_slot_1, drive_slot_0}, 16'h00E4);
        chk({8'h00, drive_type_ids}, 16'h00E4);
        host.reg_wr(8'h07, 8'hFF);
        rd_chk(8'h07, 8'hF3, 1'b1);
        chk({14'h0, boot_drive_sel}, 16'h3);
        // one enable at a time so a swapped pair of bits shows up
        for (int i = 4; i < 8; i++) begin
            host.reg_wr(8'h07, 8'h01 << i);
            chk({12'h0, apd()}, 16'h1 << (i - 4));
            chk({14'h0, boot_drive_sel}, 16'h0);
        end
        host.reg_wr(8'h08, 8'hFF);
        rd_chk(8'h08, 8'hF0, 1'b1);
        host.reg_wr(8'h09, 8'hFF);
        rd_chk(8'h09, 8'hCF, 1'b1);
        // read right behind the write must already see the new value
        host.reg_wr_rd(8'h09, 8'h3A);
        chk({8'h00, cfg_rdata}, 16'h000A);
        chk({15'h0, cfg_rdata_valid}, 16'h1);
    endtask

    task automatic t_refuse();
        host.open_cfg(1'b0);
        host.reg_wr(8'h06, 8'h00);
        host.open_cfg(1'b1);
        rd_chk(8'h06, 8'hE4, 1'b1);
        rd_chk(8'h0A, 8'h00, 1'b0);
    endtask

    task automatic t_hard();
        host.reg_wr(8'h07, 8'hF1);
        @(negedge core_clk);
        hard_reset = 1'b1;
        @(negedge core_clk);
        hard_reset = 1'b0;
        rd_chk(8'h07, 8'h01, 1'b1);
        chk({14'h0, boot_drive_sel}, 16'h1);
    endtask

    task automatic t_por();
        host.reg_wr(8'h07, 8'hF3);
        @(negedge core_clk);
        nrst = 1'b0;
        @(negedge core_clk);
        nrst = 1'b1;
        chk({12'h0, apd()}, 16'h0);
        rd_chk(8'h06, 8'hFF, 1'b1);
        rd_chk(8'h07, 8'h00, 1'b1);
    endtask

    task automatic t_decode();
        logic [15:0] addrs [6];
        logic exp;
        addrs = '{16'h0350, 16'h0357, 16'h0358, 16'h035F, 16'h1350, 16'h0360};
        host.reg_wr(8'h08, 8'h50);
        for (int m = 0; m < 4; m++) begin
            host.reg_wr(8'h09, {m[1:0], 6'h03});
            foreach (addrs[k]) begin
                host.set_addr(addrs[k]);
                // select is registered, so it answers one edge later
                @(negedge core_clk);
                exp = !((addrs[k][15:4] == 12'h035) && ((m == 3) || (m == 2 && !addrs[k][3])
                      || (m == 1 && addrs[k][3:0] == 4'h0)));
                chk({15'h0, gp_decode_select_n}, {15'h0, exp});
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // verdict and watchdog
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the whole run is under two hundred cycles; this limit is far beyond it
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        print_verdict();
    end

    initial begin
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        t_reset();
        t_fields();
        t_refuse();
        t_hard();
        t_por();
        t_decode();
        print_verdict();
    end
endmodule
`default_nettype wire
